// >>> rtl/sgn_pkg.sv
// Purpose: shared constants and types of the servo gain-switch and notch block
// Assumes: 50 MHz core clock, 16-bit configuration words
// Notes:   configuration words are stored by index; unmapped indices read zero
`default_nettype none
package sgn_pkg;
  // ****************************************
  // clock and time base
  // ****************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int MS_CYCLES    = CLK_HZ / MS_PER_S;  // core cycles per millisecond
  // ****************************************
  // register map, word indices
  // ****************************************
  localparam int         CFG_COUNT    = 19;
  localparam logic [7:0] IDX_N1_FREQ  = 8'h00;
  localparam logic [7:0] IDX_N1_QUAL  = 8'h01;
  localparam logic [7:0] IDX_N1_DEPTH = 8'h02;
  localparam logic [7:0] IDX_N2_FREQ  = 8'h03;
  localparam logic [7:0] IDX_N2_QUAL  = 8'h04;
  localparam logic [7:0] IDX_N2_DEPTH = 8'h05;
  localparam logic [7:0] IDX_MODE     = 8'h06;
  localparam logic [7:0] IDX_LEVEL    = 8'h07;
  localparam logic [7:0] IDX_HYST     = 8'h08;
  localparam logic [7:0] IDX_DELAY    = 8'h09;
  localparam logic [7:0] IDX_RAMP     = 8'h0A;
  localparam logic [7:0] IDX_SET_A    = 8'h0B;  // speed gain, integral, torque filter, pos gain
  localparam logic [7:0] IDX_SET_B    = 8'h0F;
  localparam logic [7:0] ADDR_STATUS  = 8'h13;
  localparam logic [7:0] ADDR_CUR     = 8'h14;  // four live loop values follow
  localparam logic [7:0] ADDR_CUR_END = 8'h17;
  // reset values, index 18 first
  localparam logic [CFG_COUNT-1:0][15:0] CFG_RESET = {
    16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h0100,
    16'h0005, 16'h0005, 16'h0005, 16'h0064, 16'h0000,
    16'h0000, 16'h0007, 16'h05DC, 16'h0000, 16'h0007, 16'h05DC};
  localparam logic [CFG_COUNT-1:0][15:0] CFG_MIN = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0001, 16'h0032, 16'h0000, 16'h0001, 16'h0032};
  localparam logic [CFG_COUNT-1:0][15:0] CFG_MAX = {
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'h0BB8, 16'h0BB8, 16'h7FFF, 16'h7FFF, 16'h0006,
    16'h0064, 16'h0064, 16'h05DC, 16'h0064, 16'h0064, 16'h05DC};
  // ****************************************
  // gain-switch modes and states
  // ****************************************
  localparam logic [15:0] MODE_FIXED_A   = 16'h0000;
  localparam logic [15:0] MODE_FIXED_B   = 16'h0001;
  localparam logic [15:0] MODE_DEVIATION = 16'h0004;
  localparam logic [15:0] MODE_SPEED     = 16'h0005;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_QUAL = 2'b01,
    ST_RAMP = 2'b10
  } sgn_gs_state_t;
  // ****************************************
  // notch arithmetic, Q14 fixed point, 16 kHz sample rate
  // ****************************************
  localparam int          Q_FRAC     = 14;
  localparam logic [15:0] UNITY      = 16'h4000;
  localparam logic [15:0] FREQ_SCALE = 16'h066F;  // 2*pi*2^22/16000
  localparam int          FREQ_SHIFT = 8;
  localparam logic [15:0] DEPTH_FULL = 16'h0064;  // percent
endpackage
`default_nettype wire

// >>> rtl/sgn_notch_if.sv
// Purpose: carries one notch stage's settings and samples
// Assumes: single core clock domain
// Notes:   ctrl side drives settings and input samples
`default_nettype none
interface sgn_notch_if;
  logic               sampleValid;
  logic signed [15:0] sampleIn;
  logic        [15:0] freq;
  logic        [15:0] quality;
  logic        [15:0] depth;
  logic signed [15:0] sampleOut;
  logic               outValid;
  modport ctrl (output sampleValid, sampleIn, freq, quality, depth,
                input  sampleOut, outValid);
  modport filt (input  sampleValid, sampleIn, freq, quality, depth,
                output sampleOut, outValid);
endinterface
`default_nettype wire

// >>> rtl/sgn_notch.sv
// Purpose: one notch stage, state-variable band-pass subtracted from the input
// Assumes: settings already limited to their ranges; quality is never zero
// Notes:   output follows an input sample by one cycle
`default_nettype none
module sgn_notch (
  input wire logic core_clk,  // core clock
  input wire logic reset,     // async reset, active high
  sgn_notch_if.filt nif       // settings and samples
);
  typedef struct packed {
    logic signed [31:0] lp;
    logic signed [31:0] bp;
    logic        [15:0] coefF;
    logic        [15:0] coefD;
    logic        [15:0] coefK;
    logic signed [15:0] out;
    logic               outValid;
  } sgn_notch_state_t;

  sgn_notch_state_t s;
  sgn_notch_state_t next_s;

  // signed Q14 product
  function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
                                              input logic [15:0] b);
    logic signed [48:0] p;
    p = a * signed'({1'b0, b});
    p = p >>> sgn_pkg::Q_FRAC;
    return p[31:0];
  endfunction

  // saturate to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh00007FFF)
      return 16'sh7FFF;
    else if (v < -32'sh00008000)
      return -16'sh8000;
    else
      return v[15:0];
  endfunction

  // coefficients each cycle, band-pass update on a sample
  always_comb
  begin
    logic        [31:0] fProd;
    logic        [31:0] kProd;
    logic signed [31:0] x;
    logic signed [31:0] hp;
    logic signed [31:0] band;
    fProd = {16'h0000, nif.freq} * {16'h0000, sgn_pkg::FREQ_SCALE};
    fProd = fProd >> sgn_pkg::FREQ_SHIFT;
    kProd = ({16'h0000, nif.depth} * {16'h0000, sgn_pkg::UNITY}) / {16'h0000, sgn_pkg::DEPTH_FULL};
    x = 32'(nif.sampleIn);
    hp = 32'sh0;
    band = 32'sh0;
    next_s = s;
    next_s.coefF = fProd[15:0];
    next_s.coefD = sgn_pkg::UNITY / nif.quality;
    next_s.coefK = kProd[15:0];
    next_s.outValid = nif.sampleValid;
    if (nif.sampleValid)
    begin
      next_s.lp = s.lp + mulq(s.bp, s.coefF);
      hp = x - next_s.lp - mulq(s.bp, s.coefD);
      next_s.bp = s.bp + mulq(hp, s.coefF);
      band = mulq(next_s.bp, s.coefD);
      if (s.coefK == 16'h0000)
        next_s.out = nif.sampleIn;
      else
        next_s.out = sat16(x - mulq(band, s.coefK));
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign nif.sampleOut = s.out;
  assign nif.outValid  = s.outValid;

  a_bypass_passes: assert property (@(posedge core_clk) disable iff (reset)
    (nif.sampleValid && s.coefK == 16'h0000) |=> (nif.sampleOut == $past(nif.sampleIn)))
    else $error("bypassed notch altered the sample");
endmodule
`default_nettype wire

// >>> rtl/sgn_servo_tune.sv
// Purpose: two series notch stages on the torque command and gain-set switching
// Assumes: strobes one cycle wide; deviation and speed given as magnitudes
// Notes:   read data stands in the cycle after the read strobe
//
// Summary of operation
// - first notch centre 50..1500 Hz, reset value 1500 Hz.
// - first notch depth zero passes the torque sample untouched.
// - depth 0..100 percent, default 0; larger depth attenuates more.
// - quality 1..100, default 7; larger quality narrows the notch.
// - second notch has its own centre 50..1500 Hz and quality.
// - mode 0..6; 0 holds set A, 1 holds set B, 2,3,6 reserved.
// - mode 4 picks set B when deviation exceeds the level.
// - mode 5 picks set B when motor speed exceeds the level.
// - a set is four loop values that all change together.
// - switching level 0..32767, default 100, unit per mode.
// - hysteresis 0..32767, default 5, same unit as the level.
// - switch starts only after condition held 0..3000 ms, default 5.
// - condition lost during the delay abandons the pending switch.
// - all four values ramp linearly together over the ramp time.
//
// Decided for this implementation: the address map and the strobed register port.
`default_nettype none
module sgn_servo_tune #(
  parameter int MS_CYCLES = sgn_pkg::MS_CYCLES  // cycles per millisecond
) (
  input  wire logic               core_clk,       // core clock, 50 MHz
  input  wire logic               reset,          // async reset, active high
  input  wire logic        [7:0]  regAddr,        // register word index
  input  wire logic        [15:0] regWrData,      // write data
  input  wire logic               regWrite,       // write strobe
  input  wire logic               regRead,        // read strobe
  output logic             [15:0] regRdData,      // read data, next cycle
  input  wire logic signed [15:0] torqueIn,       // torque command sample
  input  wire logic               torqueInValid,  // sample strobe
  output logic signed      [15:0] torqueOut,      // filtered torque command
  output logic                    torqueOutValid, // filtered sample strobe
  input  wire logic        [15:0] posDeviation,   // position deviation, pulses
  input  wire logic        [15:0] motorSpeed,     // motor speed, r/min
  output logic             [15:0] speedGain,      // live speed loop gain
  output logic             [15:0] speedIntegral,  // live integral time constant
  output logic             [15:0] torqueFilter,   // live torque filter constant
  output logic             [15:0] positionGain,   // live position loop gain
  output logic                    gainSetB,       // set B selected
  output logic                    gainRamping     // ramp in progress
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  typedef struct packed {
    logic [sgn_pkg::CFG_COUNT-1:0][15:0] cfg;
    logic [15:0]                         rdData;
    sgn_pkg::sgn_gs_state_t              state;
    logic                                activeSet;
    logic [15:0]                         msCnt;
    logic [11:0]                         qualMs;
    logic [11:0]                         elapsedMs;
    logic [3:0][15:0]                    cur;
    logic [3:0][15:0]                    start;
  } sgn_top_state_t;

  sgn_top_state_t s;
  sgn_top_state_t next_s;
  sgn_notch_if    stage1 ();
  sgn_notch_if    stage2 ();

  // ****************************************
  // helpers
  // ****************************************
  // limit a written word to its range
  function automatic logic [15:0] clampWord(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    else
      return v;
  endfunction

  // linear point between two values, e of t elapsed
  function automatic logic [15:0] interp(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [11:0] e,
                                         input logic [15:0] t);
    logic signed [16:0] d;
    logic signed [30:0] p;
    logic signed [30:0] q;
    logic signed [30:0] r;
    d = signed'({1'b0, b}) - signed'({1'b0, a});
    p = d * signed'({1'b0, e});
    q = p / signed'({1'b0, t});
    r = signed'({15'h0000, a}) + q;
    return r[15:0];
  endfunction

  // ****************************************
  // notch stages in series
  // ****************************************
  // first stage fed from the torque command, second from the first
  assign stage1.sampleValid = torqueInValid;
  assign stage1.sampleIn    = torqueIn;
  assign stage1.freq        = s.cfg[sgn_pkg::IDX_N1_FREQ];
  assign stage1.quality     = s.cfg[sgn_pkg::IDX_N1_QUAL];
  assign stage1.depth       = s.cfg[sgn_pkg::IDX_N1_DEPTH];
  assign stage2.sampleValid = stage1.outValid;
  assign stage2.sampleIn    = stage1.sampleOut;
  assign stage2.freq        = s.cfg[sgn_pkg::IDX_N2_FREQ];
  assign stage2.quality     = s.cfg[sgn_pkg::IDX_N2_QUAL];
  assign stage2.depth       = s.cfg[sgn_pkg::IDX_N2_DEPTH];

  sgn_notch u_notch1 (
    .core_clk (core_clk),
    .reset    (reset),
    .nif      (stage1.filt)
  );

  sgn_notch u_notch2 (
    .core_clk (core_clk),
    .reset    (reset),
    .nif      (stage2.filt)
  );

  assign torqueOut      = stage2.sampleOut;
  assign torqueOutValid = stage2.outValid;

  // ****************************************
  // switching condition
  // ****************************************
  logic [15:0] compared;
  logic [15:0] mode;
  logic [15:0] level;
  logic [15:0] hyst;
  logic        qualified;
  logic        wantB;
  logic        aboveLevel;
  logic        belowReturn;
  logic        msTick;

  assign mode        = s.cfg[sgn_pkg::IDX_MODE];
  assign level       = s.cfg[sgn_pkg::IDX_LEVEL];
  assign hyst        = s.cfg[sgn_pkg::IDX_HYST];
  assign compared    = (mode == sgn_pkg::MODE_DEVIATION) ? posDeviation : motorSpeed;
  assign aboveLevel  = compared > level;
  assign belowReturn = ({1'b0, compared} + {1'b0, hyst}) < {1'b0, level};
  assign qualified   = (mode == sgn_pkg::MODE_DEVIATION) || (mode == sgn_pkg::MODE_SPEED);
  assign msTick      = (s.msCnt == MS_LAST);

  // target set per mode; reserved modes keep the present set
  always_comb
  begin
    unique case (mode)
      sgn_pkg::MODE_FIXED_A:   wantB = 1'b0;
      sgn_pkg::MODE_FIXED_B:   wantB = 1'b1;
      sgn_pkg::MODE_DEVIATION,
      sgn_pkg::MODE_SPEED:     wantB = s.activeSet ? !belowReturn : aboveLevel;
      default:                 wantB = s.activeSet;
    endcase
  end

  // ****************************************
  // registers, switch sequencer, ramp
  // ****************************************
  always_comb
  begin
    logic [3:0][15:0] target;
    target = '0;
    next_s = s;
    for (int i = 0; i < 4; i++)
    begin
      target[i] = s.activeSet ? s.cfg[int'(sgn_pkg::IDX_SET_B) + i]
                              : s.cfg[int'(sgn_pkg::IDX_SET_A) + i];
    end
    // configuration writes, limited to the documented range
    if (regWrite && regAddr < sgn_pkg::ADDR_STATUS)
    begin
      next_s.cfg[regAddr[4:0]] = clampWord(regWrData, sgn_pkg::CFG_MIN[regAddr[4:0]],
                                           sgn_pkg::CFG_MAX[regAddr[4:0]]);
    end
    // read data, valid only in the cycle after the strobe
    next_s.rdData = 16'h0000;
    if (regRead)
    begin
      if (regAddr < sgn_pkg::ADDR_STATUS)
        next_s.rdData = s.cfg[regAddr[4:0]];
      else if (regAddr == sgn_pkg::ADDR_STATUS)
        next_s.rdData = {13'h0000, s.state == sgn_pkg::ST_RAMP,
                         s.state == sgn_pkg::ST_QUAL, s.activeSet};
      else if (regAddr <= sgn_pkg::ADDR_CUR_END && regAddr >= sgn_pkg::ADDR_CUR)
        next_s.rdData = s.cur[regAddr[1:0]];
    end
    // millisecond time base
    next_s.msCnt = msTick ? 16'h0000 : s.msCnt + 16'h0001;
    unique case (s.state)
      sgn_pkg::ST_IDLE:
      begin
        next_s.cur = target;
        if (wantB != s.activeSet)
        begin
          next_s.msCnt = 16'h0000;
          if (qualified)
          begin
            next_s.state  = sgn_pkg::ST_QUAL;
            next_s.qualMs = 12'h000;
          end
          else
          begin
            next_s.state     = sgn_pkg::ST_RAMP;
            next_s.activeSet = wantB;
            next_s.start     = s.cur;
            next_s.elapsedMs = 12'h000;
          end
        end
      end
      sgn_pkg::ST_QUAL:
      begin
        next_s.cur = target;
        if (wantB == s.activeSet)
          next_s.state = sgn_pkg::ST_IDLE;
        else if ({4'h0, s.qualMs} >= s.cfg[sgn_pkg::IDX_DELAY])
        begin
          next_s.state     = sgn_pkg::ST_RAMP;
          next_s.activeSet = wantB;
          next_s.start     = s.cur;
          next_s.elapsedMs = 12'h000;
          next_s.msCnt     = 16'h0000;
        end
        else if (msTick)
          next_s.qualMs = s.qualMs + 12'h001;
      end
      sgn_pkg::ST_RAMP:
      begin
        if ({4'h0, s.elapsedMs} >= s.cfg[sgn_pkg::IDX_RAMP])
        begin
          next_s.cur   = target;
          next_s.state = sgn_pkg::ST_IDLE;
        end
        else
        begin
          for (int i = 0; i < 4; i++)
          begin
            next_s.cur[i] = interp(s.start[i], target[i], s.elapsedMs,
                                   s.cfg[sgn_pkg::IDX_RAMP]);
          end
          if (msTick)
            next_s.elapsedMs = s.elapsedMs + 12'h001;
        end
      end
      default:
        next_s.state = sgn_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s           <= '0;
      s.cfg       <= sgn_pkg::CFG_RESET;
      s.cur       <= sgn_pkg::CFG_RESET[int'(sgn_pkg::IDX_SET_A) +: 4];
      s.state     <= sgn_pkg::ST_IDLE;
    end
    else
      s <= next_s;
  end

  // outputs
  assign regRdData     = s.rdData;
  assign speedGain     = s.cur[0];
  assign speedIntegral = s.cur[1];
  assign torqueFilter  = s.cur[2];
  assign positionGain  = s.cur[3];
  assign gainSetB      = s.activeSet;
  assign gainRamping   = (s.state == sgn_pkg::ST_RAMP);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_fixed_mode_a: assert property (
    (s.state == sgn_pkg::ST_IDLE && mode == sgn_pkg::MODE_FIXED_A && s.activeSet)
      |=> (s.state == sgn_pkg::ST_RAMP && !s.activeSet))
    else $error("mode 0 did not return to set A");

  a_deviation_starts: assert property (
    (s.state == sgn_pkg::ST_IDLE && mode == sgn_pkg::MODE_DEVIATION && !s.activeSet
     && posDeviation > level) |=> (s.state == sgn_pkg::ST_QUAL))
    else $error("deviation above level did not start qualifying");

  a_speed_starts: assert property (
    (s.state == sgn_pkg::ST_IDLE && mode == sgn_pkg::MODE_SPEED && !s.activeSet
     && motorSpeed > level) |=> (s.state == sgn_pkg::ST_QUAL))
    else $error("speed above level did not start qualifying");

  a_delay_honoured: assert property (
    (s.state == sgn_pkg::ST_QUAL && {4'h0, s.qualMs} < s.cfg[sgn_pkg::IDX_DELAY])
      |=> (s.state != sgn_pkg::ST_RAMP))
    else $error("switch began before the qualifying delay");

  a_abandon_keeps: assert property (
    (s.state == sgn_pkg::ST_QUAL && wantB == s.activeSet)
      |=> (s.state == sgn_pkg::ST_IDLE && s.activeSet == $past(s.activeSet)))
    else $error("lost condition did not abandon the switch");

  a_ramp_lands: assert property (
    (s.state == sgn_pkg::ST_RAMP && {4'h0, s.elapsedMs} >= s.cfg[sgn_pkg::IDX_RAMP]
     && !regWrite) |=> (speedGain == $past(target_probe(0))
                        && positionGain == $past(target_probe(3))))
    else $error("gain set did not land on target together");

  a_hyst_holds: assert property (
    (s.state == sgn_pkg::ST_IDLE && mode == sgn_pkg::MODE_DEVIATION && s.activeSet
     && !belowReturn) |=> (s.state == sgn_pkg::ST_IDLE && s.activeSet))
    else $error("set B left inside the hysteresis band");

  a_ramp_monotone: assert property (
    (s.state == sgn_pkg::ST_RAMP && $past(s.state) == sgn_pkg::ST_RAMP && msTick)
      |=> (s.elapsedMs == $past(s.elapsedMs) + 12'h001 || s.state == sgn_pkg::ST_IDLE))
    else $error("ramp time base stalled");

  a_level_range: assert property (
    level <= sgn_pkg::CFG_MAX[sgn_pkg::IDX_LEVEL] && hyst <= sgn_pkg::CFG_MAX[sgn_pkg::IDX_HYST])
    else $error("switching level or hysteresis out of range");

  c_abandon: cover property (s.state == sgn_pkg::ST_QUAL ##1 s.state == sgn_pkg::ST_IDLE);
  c_ramp_b:  cover property (s.state == sgn_pkg::ST_RAMP && s.activeSet);
  c_back_a:  cover property (s.activeSet ##[1:1000] !s.activeSet);
  c_filter:  cover property (torqueOutValid && s.cfg[sgn_pkg::IDX_N1_DEPTH] != 16'h0000);

  // helper for the landing check
  function automatic logic [15:0] target_probe(input int i);
    return s.activeSet ? s.cfg[int'(sgn_pkg::IDX_SET_B) + i]
                       : s.cfg[int'(sgn_pkg::IDX_SET_A) + i];
  endfunction
endmodule
`default_nettype wire

// >>> dv/sgn_loop_model.sv
// Purpose: far-side loop model, hands torque samples to the block
// Assumes: one core clock
// Notes:   sample line toggles every cycle while not valid
`default_nettype none
module sgn_loop_model (
  input  wire logic               core_clk,              // core clock
  input  wire logic               fire,                  // send one sample
  input  wire logic signed [15:0] cmdTorque,             // sample to send
  output var logic signed  [15:0] torqueIn = 16'h0000,   // torque sample
  output var logic                torqueInValid = 1'b0   // one-cycle strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // one strobe per request, junk on the line otherwise
  always @(posedge core_clk)
  begin
    torqueInValid <= fire;
    torqueIn      <= fire ? cmdTorque : ~torqueIn;
  end
endmodule
`default_nettype wire

// >>> dv/sgn_servo_tune_bench.sv
// Purpose: self-checking bench of the gain-switch and notch block
// Assumes: one ms is 10 cycles here
// Notes:   expected words come from the tables below
`default_nettype none
module sgn_servo_tune_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // signals and model tables
  // ****
  logic               core_clk = 1'b0;
  logic               reset = 1'b1;
  logic        [7:0]  regAddr = 8'h00;
  logic        [15:0] regWrData = 16'h0000;
  logic               regWrite = 1'b0;
  logic               regRead = 1'b0;
  logic        [15:0] regRdData, speedGain, speedIntegral, torqueFilter, positionGain;
  logic signed [15:0] torqueIn, torqueOut, cmdTorque = 16'h0000;
  logic               torqueInValid, torqueOutValid, gainSetB, gainRamping;
  logic               fire = 1'b0;
  logic        [15:0] posDeviation = 16'h0000;
  logic        [15:0] motorSpeed = 16'h0000;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'h374B902E;
  int rnd;
  logic        [15:0] expQ[$];  // expected bypass samples, oldest first
  int rstVal[19] = '{1500,7,0,1500,7,0,0,100,5,5,5,256,256,256,256,512,512,512,512};
  int clIdx[9] = '{0,0,1,2,3,4,6,7,9};
  int clIn[9] = '{10,2000,0,200,9,500,9,65535,4000};
  int clOut[9] = '{50,1500,1,100,50,100,6,32767,3000};
  sgn_servo_tune #(.MS_CYCLES(10)) dut (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .torqueIn(torqueIn), .torqueInValid(torqueInValid),
    .torqueOut(torqueOut), .torqueOutValid(torqueOutValid), .posDeviation(posDeviation),
    .motorSpeed(motorSpeed), .speedGain(speedGain), .speedIntegral(speedIntegral),
    .torqueFilter(torqueFilter), .positionGain(positionGain), .gainSetB(gainSetB),
    .gainRamping(gainRamping));
  sgn_loop_model loop (.core_clk(core_clk), .fire(fire), .cmdTorque(cmdTorque),
    .torqueIn(torqueIn), .torqueInValid(torqueInValid));
  // clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_near(input logic signed [15:0] got, input int exp, input int tol);
    compares++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol)
    begin
      failures++;
      $display("Error %0t: got %0d expected near %0d", $time, got, exp);
    end
  endtask
  task automatic check_set(input logic b);
    logic [15:0] v;
    v = rstVal[b ? 15 : 11][15:0];
    check_word({15'h0000, gainSetB}, {15'h0000, b});
    check_word(speedGain, v);
    check_word(speedIntegral, v);
    check_word(torqueFilter, v);
    check_word(positionGain, v);
  endtask
  task automatic wr(input int a, input int d);
    @(posedge core_clk);
    regAddr   <= a[7:0];
    regWrData <= d[15:0];
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
  endtask
  task automatic rd(input int a, input int e);
    @(posedge core_clk);
    regAddr <= a[7:0];
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check_word(regRdData, e[15:0]);
  endtask
  task automatic wait_for(input logic want);
    for (int n = 0; n < 200; n++)
    begin
      @(posedge core_clk);
      #1;
      if (gainSetB === want && gainRamping === 1'b0)
        break;
    end
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 19; i++)
      rd(i, rstVal[i]);
    rd(32, 0);
    for (int i = 0; i < 9; i++)
    begin
      wr(clIdx[i], clIn[i]);
      rd(clIdx[i], clOut[i]);
    end
    // both depths zero: samples pass untouched
    wr(2, 0);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge core_clk);
      rnd = $random(seed);
      cmdTorque <= rnd[15:0];
      expQ.push_back(rnd[15:0]);
      fire      <= 1'b1;
      @(posedge core_clk);
      fire      <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check_word(torqueOut, expQ.pop_front());
      check_word({15'h0000, torqueOutValid}, 16'h0001);
    end
    // first stage at full depth still passes a steady level
    wr(2, 100);
    cmdTorque <= 16'h03E8;
    for (int i = 0; i < 200; i++)
    begin
      @(posedge core_clk);
      fire <= ~fire;
    end
    repeat (3) @(posedge core_clk);
    #1 check_near(torqueOut, 1000, 16);
    // fixed modes, then deviation and speed modes
    wr(6, 1);
    @(posedge core_clk);
    #1 check_word({15'h0000, gainRamping}, 16'h0001);
    repeat (25) @(posedge core_clk);
    #1 check_word(speedGain, 16'(rstVal[11] + (rstVal[15] - rstVal[11]) * 2 / 5));
    check_word(positionGain, 16'(rstVal[14] + (rstVal[18] - rstVal[14]) * 2 / 5));
    wait_for(1'b1);
    check_set(1'b1);
    rd(19, 1);
    rd(20, 512);
    wr(6, 0);
    wait_for(1'b0);
    check_set(1'b0);
    wr(7, 100);
    wr(9, 3);
    wr(10, 0);
    wr(6, 4);
    posDeviation <= 16'd101;
    repeat (15) @(posedge core_clk);
    posDeviation <= 16'd50;
    repeat (60) @(posedge core_clk);
    #1 check_set(1'b0);
    posDeviation <= 16'd101;
    repeat (20) @(posedge core_clk);
    #1 check_set(1'b0);
    wait_for(1'b1);
    check_set(1'b1);
    posDeviation <= 16'd97;
    repeat (60) @(posedge core_clk);
    #1 check_set(1'b1);
    posDeviation <= 16'd94;
    wait_for(1'b0);
    check_set(1'b0);
    wr(6, 5);
    posDeviation <= 16'd500;
    motorSpeed <= 16'd200;
    wait_for(1'b1);
    check_set(1'b1);
    motorSpeed <= 16'd0;
    wait_for(1'b0);
    check_set(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
